// File: dv/dsp_cpu_register_file_test.sv
`timescale 1ns/1ps
module dsp_cpu_register_file_test;
  import dcrf_pkg::*;
  typedef struct {int unsigned due; int unsigned which; logic [31:0] val;} dcrf_note_t;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  dcrf_gwr_t gp_wr;
  dcrf_cwr_t ctl_wr;
  dcrf_areq_t x_req, y_req, s_req;
  dcrf_ctl_sel_t ctl_rd_sel;
  logic [3:0] gp_rd_a_idx, gp_rd_b_idx;
  logic exc_start, rte_start, rc_dec;
  logic [7:0] exc_vec_num;
  logic [31:0] pc_in, stk_rdata;
  logic [31:0] gp_rd_a_r, gp_rd_b_r, index_reg_r, ctl_rd_r, gbase_ea_r, x_addr_r, y_addr_r, s_addr_r;
  logic [31:0] stk_addr_r, stk_wdata_r, vec_addr_r, ret_pc_r, loop_start_addr, loop_end_addr;
  logic stk_we_r, stk_re_r, exc_busy_r, rc_in_range_r, x_modulo_enable, y_modulo_enable;
  logic [11:0] iteration_count;
  logic [2:0] loop_steps_r;
  logic [31:0] gv [16];
  int unsigned cyc = 0;
  int unsigned miscompares = 0;
  int unsigned cmp_count = 0;
  int unsigned seed_r;
  dcrf_note_t notes[$];

  dcrf_core u_dcrf_core (.clk_sys(clk_sys), .rst_n(rst_n), .gp_wr(gp_wr), .gp_rd_a_idx(gp_rd_a_idx),
    .gp_rd_b_idx(gp_rd_b_idx), .gp_rd_a_r(gp_rd_a_r), .gp_rd_b_r(gp_rd_b_r), .index_reg_r(index_reg_r),
    .ctl_wr(ctl_wr), .ctl_rd_sel(ctl_rd_sel), .ctl_rd_r(ctl_rd_r), .gbase_ea_r(gbase_ea_r),
    .x_req(x_req), .y_req(y_req), .s_req(s_req), .x_addr_r(x_addr_r), .y_addr_r(y_addr_r),
    .s_addr_r(s_addr_r), .exc_start(exc_start), .exc_vec_num(exc_vec_num), .pc_in(pc_in),
    .rte_start(rte_start), .stk_rdata(stk_rdata), .stk_addr_r(stk_addr_r), .stk_wdata_r(stk_wdata_r),
    .stk_we_r(stk_we_r), .stk_re_r(stk_re_r), .vec_addr_r(vec_addr_r), .ret_pc_r(ret_pc_r),
    .exc_busy_r(exc_busy_r), .rc_dec(rc_dec), .loop_start_addr(loop_start_addr),
    .loop_end_addr(loop_end_addr), .iteration_count(iteration_count), .rc_in_range_r(rc_in_range_r),
    .loop_steps_r(loop_steps_r), .x_modulo_enable(x_modulo_enable), .y_modulo_enable(y_modulo_enable));

  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc <= cyc + 1;

  function automatic logic [31:0] seen(int unsigned w);
    case (w)
      0: seen = gp_rd_a_r;
      1: seen = ctl_rd_r;
      2: seen = x_addr_r;
      3: seen = y_addr_r;
      4: seen = s_addr_r;
      5: seen = stk_addr_r;
      6: seen = stk_wdata_r;
      7: seen = vec_addr_r;
      8: seen = ret_pc_r;
      9: seen = {29'h0, loop_steps_r};
      10: seen = {20'h0, iteration_count};
      11: seen = index_reg_r;
      12: seen = gbase_ea_r;
      13: seen = {26'h0, rc_in_range_r, x_modulo_enable, y_modulo_enable, stk_we_r, stk_re_r, exc_busy_r};
      14: seen = gp_rd_b_r;
      15: seen = loop_start_addr;
      default: seen = loop_end_addr;
    endcase
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask

  task automatic note_exp(input int unsigned dly, input int unsigned w, input logic [31:0] v);
    notes.push_back('{cyc + dly, w, v});
  endtask

  // watcher: settled outputs at the falling edge against due notes
  always @(negedge clk_sys) begin
    int i;
    i = 0;
    while (i < notes.size()) begin
      if (notes[i].due == cyc) begin
        check(seen(notes[i].which), notes[i].val);
        notes.delete(i);
      end else begin
        i++;
      end
    end
  end

  task automatic gwr(input logic [3:0] i, input logic [31:0] d);
    @(negedge clk_sys);
    gp_wr = '{en: 1'b1, idx: i, data: d};
    @(negedge clk_sys);
    gp_wr.en = 1'b0;
  endtask

  task automatic cwr(input dcrf_ctl_sel_t s, input logic [31:0] d);
    @(negedge clk_sys);
    ctl_wr = '{en: 1'b1, sel: s, data: d};
    @(negedge clk_sys);
    ctl_wr.en = 1'b0;
  endtask

  task automatic crd(input logic [2:0] s, input logic [31:0] exp);
    @(negedge clk_sys);
    ctl_rd_sel = dcrf_ctl_sel_t'(s);
    note_exp(1, 1, exp);
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk_sys);
    miscompares++;
    finish_test();
  end

  initial begin
    logic [31:0] cv [6];
    logic [2:0] steps [4];
    gp_wr = '0; ctl_wr = '0; x_req = '0; y_req = '0; s_req = '0;
    ctl_rd_sel = CS_STATUS; gp_rd_a_idx = 4'h0; gp_rd_b_idx = 4'h0;
    exc_start = 1'b0; rte_start = 1'b0; rc_dec = 1'b0; exc_vec_num = 8'h00; pc_in = 32'h0;
    seed_r = $urandom(32'hC1AC);
    stk_rdata = $urandom;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    rst_n = 1'b1;
    note_exp(1, 9, 32'h1);
    note_exp(1, 1, 32'h0);
    for (int i = 0; i < 16; i++) begin
      gv[i] = $urandom;
      gwr(i[3:0], gv[i]);
    end
    for (int i = 0; i < 16; i++) begin
      @(negedge clk_sys);
      gp_rd_a_idx = i[3:0];
      gp_rd_b_idx = 4'(15 - i);
      note_exp(1, 0, gv[i]);
      note_exp(1, 14, gv[15 - i]);
    end
    note_exp(1, 11, gv[0]);
    cv = '{32'h0FFF_07FF, $urandom, $urandom, $urandom, $urandom, $urandom};
    for (int s = 0; s < 6; s++) cwr(dcrf_ctl_sel_t'(s), cv[s]);
    note_exp(1, 12, cv[1] + gv[0]);
    note_exp(1, 10, 32'hFFF);
    note_exp(1, 13, 32'h30);
    note_exp(1, 15, cv[3]);
    note_exp(1, 16, cv[4]);
    crd(3'h0, 32'h0FFF_07FF);
    for (int s = 1; s < 6; s++) crd(s[2:0], cv[s]);
    crd(3'h6, 32'h0);
    steps = '{3'h1, 3'h2, 3'h4, 3'h3};
    for (int rf = 0; rf < 4; rf++) begin
      cwr(CS_STATUS, 32'h0002_0000 | (rf << 2));
      note_exp(1, 9, steps[rf]);
    end
    note_exp(1, 13, 32'h20);
    for (int n = 0; n < 3; n++) begin
      @(negedge clk_sys);
      rc_dec = 1'b1;
      @(negedge clk_sys);
      rc_dec = 1'b0;
      note_exp(1, 10, (n == 0) ? 32'h1 : 32'h0);
      note_exp(1, 13, 32'h0);
    end
    cwr(CS_MOD, 32'h0104_0100);
    cwr(CS_STATUS, 32'h0000_0400);
    gwr(4'h4, 32'h1234_0100);
    gwr(4'h5, 32'h0000_0102);
    gwr(4'h6, 32'h0000_2000);
    gwr(4'h9, 32'h0000_0010);
    for (int j = 0; j < 3; j++) begin
      @(negedge clk_sys);
      x_req = '{en: 1'b1, sel: 2'h0, mode: AM_INC};
      s_req = '{en: 1'b1, sel: 2'h3, mode: AM_INC};
      y_req = '{en: 1'b1, sel: 2'h0, mode: (j == 0) ? AM_IDX : ((j == 1) ? AM_DEC : AM_INC)};
      note_exp(1, 2, (j == 1) ? 32'h1234_0102 : 32'h1234_0100);
      note_exp(1, 4, 32'h0000_0102 + 2 * j);
      note_exp(1, 3, (j == 0) ? 32'h2000 : ((j == 1) ? 32'h2010 : 32'h200E));
    end
    @(negedge clk_sys);
    x_req = '0;
    s_req = '0;
    y_req = '{en: 1'b1, sel: 2'h1, mode: AM_NONE};
    note_exp(1, 3, gv[7]);
    @(negedge clk_sys);
    y_req = '0;
    cwr(CS_VBASE, 32'h0000_8000);
    gwr(4'hF, 32'h0000_1000);
    cwr(CS_STATUS, 32'h0123_0456);
    @(negedge clk_sys);
    exc_start = 1'b1; exc_vec_num = 8'h0B; pc_in = 32'hCAFE_0010;
    note_exp(1, 13, 32'h31);
    note_exp(2, 13, 32'h35);
    note_exp(3, 13, 32'h34);
    note_exp(2, 5, 32'h0000_0FFC);
    note_exp(2, 6, 32'h0123_0456);
    note_exp(3, 5, 32'h0000_0FF8);
    note_exp(3, 6, 32'hCAFE_0010);
    note_exp(3, 7, 32'h0000_802C);
    @(negedge clk_sys);
    exc_start = 1'b0;
    repeat (3) @(negedge clk_sys);
    gp_rd_b_idx = 4'hF;
    note_exp(1, 14, 32'h0000_0FF8);
    cwr(CS_STATUS, 32'h0);
    @(negedge clk_sys);
    rte_start = 1'b1;
    note_exp(1, 13, 32'h01);
    note_exp(2, 13, 32'h03);
    note_exp(3, 13, 32'h03);
    note_exp(4, 13, 32'h10);
    note_exp(2, 5, 32'h0000_0FF8);
    note_exp(3, 5, 32'h0000_0FFC);
    note_exp(4, 8, 32'hCAFE_0010);
    @(negedge clk_sys);
    rte_start = 1'b0;
    @(negedge clk_sys);
    stk_rdata = 32'hCAFE_0010;
    @(negedge clk_sys);
    stk_rdata = 32'h0123_0456;
    @(negedge clk_sys);
    stk_rdata = ~stk_rdata;
    ctl_rd_sel = CS_STATUS;
    note_exp(1, 1, 32'h0123_0456);
    note_exp(1, 14, 32'h0000_1000);
    for (int w = 0; w < 20 && notes.size() > 0; w++) @(negedge clk_sys);
    if (notes.size() > 0) miscompares++;
    finish_test();
  end
endmodule

// File: src/dcrf_core.sv
`timescale 1ns/1ps
module dcrf_core (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // general register write and reads
  input wire dcrf_pkg::dcrf_gwr_t gp_wr,
  input wire logic [3:0] gp_rd_a_idx,
  input wire logic [3:0] gp_rd_b_idx,
  output logic [31:0] gp_rd_a_r,
  output logic [31:0] gp_rd_b_r,
  output logic [31:0] index_reg_r,
  // control register access
  input wire dcrf_pkg::dcrf_cwr_t ctl_wr,
  input wire dcrf_pkg::dcrf_ctl_sel_t ctl_rd_sel,
  output logic [31:0] ctl_rd_r,
  output logic [31:0] gbase_ea_r,
  // dsp address requests
  input wire dcrf_pkg::dcrf_areq_t x_req,
  input wire dcrf_pkg::dcrf_areq_t y_req,
  input wire dcrf_pkg::dcrf_areq_t s_req,
  output logic [31:0] x_addr_r,
  output logic [31:0] y_addr_r,
  output logic [31:0] s_addr_r,
  // exception stacking
  input wire logic exc_start,
  input wire logic [7:0] exc_vec_num,
  input wire logic [31:0] pc_in,
  input wire logic rte_start,
  input wire logic [31:0] stk_rdata,
  output logic [31:0] stk_addr_r,
  output logic [31:0] stk_wdata_r,
  output logic stk_we_r,
  output logic stk_re_r,
  output logic [31:0] vec_addr_r,
  output logic [31:0] ret_pc_r,
  output logic exc_busy_r,
  // loop and modulo state
  input wire logic rc_dec,
  output logic [31:0] loop_start_addr,
  output logic [31:0] loop_end_addr,
  output logic [11:0] iteration_count,
  output logic rc_in_range_r,
  output logic [2:0] loop_steps_r,
  output logic x_modulo_enable,
  output logic y_modulo_enable
);
  import dcrf_pkg::*;

  logic [31:0] gpr_r [GPR_NUM];
  logic [31:0] gpr_nxt [GPR_NUM];
  logic [31:0] status_r, gbase_r, vbase_r, lstart_r, lend_r, modb_r;
  logic [31:0] status_nxt;
  dcrf_state_t state_r, state_nxt;
  logic [31:0] pc_hold_r;
  logic [7:0] vec_hold_r;

  // stack sequencer decode
  logic push_w, pop_w, sp_we;
  logic [31:0] sp_cur, sp_nxt, stk_addr_nxt, stk_wdata_nxt;
  assign sp_cur = gpr_r[SP_REG];
  assign push_w = (state_r == ST_PSH_SR) || (state_r == ST_PSH_PC);
  assign pop_w = (state_r == ST_POP_PC) || (state_r == ST_POP_SR);
  assign sp_we = push_w || pop_w;
  assign sp_nxt = push_w ? sp_cur - STK_STEP : sp_cur + STK_STEP;
  assign stk_addr_nxt = push_w ? sp_cur - STK_STEP : sp_cur;
  assign stk_wdata_nxt = (state_r == ST_PSH_SR) ? status_r : pc_hold_r;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (exc_start) begin
          state_nxt = ST_PSH_SR;
        end else if (rte_start) begin
          state_nxt = ST_POP_PC;
        end
      end
      ST_PSH_SR: state_nxt = ST_PSH_PC;
      ST_PSH_PC: state_nxt = ST_IDLE;
      ST_POP_PC: state_nxt = ST_POP_SR;
      ST_POP_SR: state_nxt = ST_POP_END;
      ST_POP_END: state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  // dsp address channels: 0 x, 1 y, 2 single
  dcrf_areq_t ch_req [3];
  logic [3:0] ch_ptr_idx [3];
  logic [3:0] ch_ix_idx [3];
  logic ch_mod_en [3];
  logic ch_we [3];
  logic [31:0] ch_delta [3];
  logic [31:0] ch_new [3];
  assign ch_req[0] = x_req;
  assign ch_req[1] = y_req;
  assign ch_req[2] = s_req;
  assign ch_ptr_idx[0] = X_PTR0 + {3'h0, x_req.sel[0]};
  assign ch_ptr_idx[1] = Y_PTR0 + {3'h0, y_req.sel[0]};
  assign ch_ptr_idx[2] = S_PTR0 + {2'h0, s_req.sel};
  assign ch_ix_idx[0] = X_IDX;
  assign ch_ix_idx[1] = Y_IDX;
  assign ch_ix_idx[2] = S_IDX;
  assign ch_mod_en[0] = status_r[SR_DMX_BIT];
  assign ch_mod_en[1] = status_r[SR_DMY_BIT];
  assign ch_mod_en[2] = 1'b0;

  genvar c;
  generate
    for (c = 0; c < 3; c++) begin : g_chan
      assign ch_we[c] = ch_req[c].en && (ch_req[c].mode != AM_NONE);
      assign ch_delta[c] = (ch_req[c].mode == AM_INC) ? PTR_STEP :
                           (ch_req[c].mode == AM_DEC) ? (32'h0000_0000 - PTR_STEP) :
                           (ch_req[c].mode == AM_IDX) ? gpr_r[ch_ix_idx[c]] : 32'h0000_0000;
      dcrf_modulo u_mod (
        .ptr(gpr_r[ch_ptr_idx[c]]),
        .delta(ch_delta[c]),
        .mod_en(ch_mod_en[c]),
        .bounds(modb_r),
        .ptr_nxt(ch_new[c])
      );
    end
  endgenerate

  // per-register next value: stack, X, Y, single, pipeline write
  genvar i;
  generate
    for (i = 0; i < GPR_NUM; i++) begin : g_gpr
      assign gpr_nxt[i] = (sp_we && (SP_REG == 4'(i))) ? sp_nxt :
                          (ch_we[0] && (ch_ptr_idx[0] == 4'(i))) ? ch_new[0] :
                          (ch_we[1] && (ch_ptr_idx[1] == 4'(i))) ? ch_new[1] :
                          (ch_we[2] && (ch_ptr_idx[2] == 4'(i))) ? ch_new[2] :
                          (gp_wr.en && (gp_wr.idx == 4'(i))) ? gp_wr.data : gpr_r[i];
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          gpr_r[i] <= 32'h0000_0000;
        end else begin
          gpr_r[i] <= gpr_nxt[i];
        end
      end
    end
  endgenerate

  // status word update
  logic [11:0] rc_cur;
  logic rc_do_dec;
  assign rc_cur = status_r[SR_RC_HI:SR_RC_LO];
  assign rc_do_dec = rc_dec && (rc_cur != RC_ZERO);
  always_comb begin
    status_nxt = status_r;
    if (state_r == ST_POP_END) begin
      status_nxt = stk_rdata & SR_WMASK;
    end else if (ctl_wr.en && (ctl_wr.sel == CS_STATUS)) begin
      status_nxt = ctl_wr.data & SR_WMASK;
    end else if (rc_do_dec) begin
      status_nxt[SR_RC_HI:SR_RC_LO] = rc_cur - 12'h001;
    end
  end

  // control read mux
  logic [31:0] ctl_rd_w;
  assign ctl_rd_w = (ctl_rd_sel == CS_STATUS) ? status_r :
                    (ctl_rd_sel == CS_GBASE) ? gbase_r :
                    (ctl_rd_sel == CS_VBASE) ? vbase_r :
                    (ctl_rd_sel == CS_LSTART) ? lstart_r :
                    (ctl_rd_sel == CS_LEND) ? lend_r :
                    (ctl_rd_sel == CS_MOD) ? modb_r : 32'h0000_0000;

  // loop length decode
  logic [2:0] loop_steps_w;
  assign loop_steps_w = (status_r[SR_RF_HI:SR_RF_LO] == LEN_1) ? 3'h1 :
                        (status_r[SR_RF_HI:SR_RF_LO] == LEN_2) ? 3'h2 :
                        (status_r[SR_RF_HI:SR_RF_LO] == LEN_3) ? 3'h3 : 3'h4;

  logic cw_g, cw_v, cw_s, cw_e, cw_m;
  assign cw_g = ctl_wr.en && (ctl_wr.sel == CS_GBASE);
  assign cw_v = ctl_wr.en && (ctl_wr.sel == CS_VBASE);
  assign cw_s = ctl_wr.en && (ctl_wr.sel == CS_LSTART);
  assign cw_e = ctl_wr.en && (ctl_wr.sel == CS_LEND);
  assign cw_m = ctl_wr.en && (ctl_wr.sel == CS_MOD);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      status_r <= SR_RST;
      gbase_r <= CTL_RST;
      vbase_r <= CTL_RST;
      lstart_r <= CTL_RST;
      lend_r <= CTL_RST;
      modb_r <= CTL_RST;
    end else begin
      status_r <= status_nxt;
      gbase_r <= cw_g ? ctl_wr.data : gbase_r;
      vbase_r <= cw_v ? ctl_wr.data : vbase_r;
      lstart_r <= cw_s ? ctl_wr.data : lstart_r;
      lend_r <= cw_e ? ctl_wr.data : lend_r;
      modb_r <= cw_m ? ctl_wr.data : modb_r;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      pc_hold_r <= 32'h0000_0000;
      vec_hold_r <= 8'h00;
      stk_addr_r <= 32'h0000_0000;
      stk_wdata_r <= 32'h0000_0000;
      stk_we_r <= 1'b0;
      stk_re_r <= 1'b0;
      vec_addr_r <= 32'h0000_0000;
      ret_pc_r <= 32'h0000_0000;
      exc_busy_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      pc_hold_r <= (state_r == ST_IDLE && exc_start) ? pc_in : pc_hold_r;
      vec_hold_r <= (state_r == ST_IDLE && exc_start) ? exc_vec_num : vec_hold_r;
      stk_addr_r <= sp_we ? stk_addr_nxt : stk_addr_r;
      stk_wdata_r <= push_w ? stk_wdata_nxt : stk_wdata_r;
      stk_we_r <= push_w;
      stk_re_r <= pop_w;
      vec_addr_r <= (state_r == ST_PSH_PC) ? vbase_r + ({24'h00_0000, vec_hold_r} << VEC_SHIFT) : vec_addr_r;
      ret_pc_r <= (state_r == ST_POP_SR) ? stk_rdata : ret_pc_r;
      exc_busy_r <= (state_nxt != ST_IDLE);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      gp_rd_a_r <= 32'h0000_0000;
      gp_rd_b_r <= 32'h0000_0000;
      index_reg_r <= 32'h0000_0000;
      ctl_rd_r <= 32'h0000_0000;
      gbase_ea_r <= 32'h0000_0000;
      x_addr_r <= 32'h0000_0000;
      y_addr_r <= 32'h0000_0000;
      s_addr_r <= 32'h0000_0000;
      rc_in_range_r <= 1'b0;
      loop_steps_r <= 3'h1;
    end else begin
      gp_rd_a_r <= gpr_r[gp_rd_a_idx];
      gp_rd_b_r <= gpr_r[gp_rd_b_idx];
      index_reg_r <= gpr_r[IDX_REG];
      ctl_rd_r <= ctl_rd_w;
      gbase_ea_r <= gbase_r + gpr_r[IDX_REG];
      x_addr_r <= x_req.en ? gpr_r[ch_ptr_idx[0]] : x_addr_r;
      y_addr_r <= y_req.en ? gpr_r[ch_ptr_idx[1]] : y_addr_r;
      s_addr_r <= s_req.en ? gpr_r[ch_ptr_idx[2]] : s_addr_r;
      rc_in_range_r <= (rc_cur >= RC_MIN);
      loop_steps_r <= loop_steps_w;
    end
  end

  // loop bounds go out untouched for the fetch unit to interpret
  assign loop_start_addr = lstart_r;
  assign loop_end_addr = lend_r;
  assign iteration_count = status_r[SR_RC_HI:SR_RC_LO];
  assign x_modulo_enable = status_r[SR_DMX_BIT];
  assign y_modulo_enable = status_r[SR_DMY_BIT];

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sp_push_dec_a: assert property ((state_r == ST_PSH_SR) |=> gpr_r[SP_REG] == $past(gpr_r[SP_REG]) - STK_STEP)
    else $error("stack pointer not decremented on push");
  rte_seq_a: assert property ((state_r == ST_IDLE && rte_start && !exc_start)
    |=> (state_r == ST_POP_PC) ##1 (state_r == ST_POP_SR) ##1 (state_r == ST_POP_END) ##1 (state_r == ST_IDLE))
    else $error("return sequence out of order");
  sr_reserved_a: assert property ((status_r & ~SR_WMASK) == 32'h0000_0000)
    else $error("reserved status bits set");
  single_nomod_a: assert property (ch_we[2] |-> ch_new[2] == gpr_r[ch_ptr_idx[2]] + ch_delta[2])
    else $error("modulo applied to single transfer");
  x_mod_wrap_a: assert property ((ch_we[0] && status_r[SR_DMX_BIT]
    && ((gpr_r[ch_ptr_idx[0]][15:0] + ch_delta[0][15:0]) == modb_r[31:16])) |-> ch_new[0][15:0] == modb_r[15:0])
    else $error("x pointer did not wrap to modulo start");
  vec_addr_a: assert property ((state_r == ST_PSH_PC)
    |=> vec_addr_r == $past(vbase_r) + ({24'h00_0000, $past(vec_hold_r)} << VEC_SHIFT))
    else $error("vector address wrong");
  gbase_ea_a: assert property (1'b1 |=> gbase_ea_r == $past(gbase_r) + $past(gpr_r[IDX_REG]))
    else $error("global base address wrong");
  loop_len_a: assert property ((status_r[SR_RF_HI:SR_RF_LO] == LEN_4P) |=> loop_steps_r == 3'h4)
    else $error("loop length decode wrong");
  y_ptr_sel_a: assert property ((y_req.en && y_req.sel[0]) |=> y_addr_r == $past(gpr_r[Y_PTR0 + 4'h1]))
    else $error("y pointer selection wrong");
endmodule

// File: src/dcrf_modulo.sv
`timescale 1ns/1ps
module dcrf_modulo (
  // pointer and step
  input wire logic [31:0] ptr,
  input wire logic [31:0] delta,
  // modulo control
  input wire logic mod_en,
  input wire logic [31:0] bounds,
  // updated pointer
  output logic [31:0] ptr_nxt
);
  logic [31:0] sum;
  logic wrap;
  assign sum = ptr + delta;
  assign wrap = mod_en && (sum[15:0] == bounds[31:16]);
  assign ptr_nxt = wrap ? {sum[31:16], bounds[15:0]} : sum;
endmodule

// File: src/dcrf_pkg.sv
package dcrf_pkg;
  localparam int unsigned GPR_NUM = 16;
  localparam logic [3:0] IDX_REG = 4'h0;
  localparam logic [3:0] SP_REG = 4'hF;
  localparam logic [3:0] X_PTR0 = 4'h4;
  localparam logic [3:0] Y_PTR0 = 4'h6;
  localparam logic [3:0] S_PTR0 = 4'h2;
  localparam logic [3:0] X_IDX = 4'h8;
  localparam logic [3:0] Y_IDX = 4'h9;
  localparam logic [3:0] S_IDX = 4'h8;
  localparam int unsigned SR_RC_HI = 27;
  localparam int unsigned SR_RC_LO = 16;
  localparam int unsigned SR_DMY_BIT = 11;
  localparam int unsigned SR_DMX_BIT = 10;
  localparam int unsigned SR_RF_HI = 3;
  localparam int unsigned SR_RF_LO = 2;
  localparam logic [31:0] SR_WMASK = 32'h0FFF_0FFF;
  localparam logic [31:0] SR_RST = 32'h0000_0000;
  localparam logic [31:0] CTL_RST = 32'h0000_0000;
  localparam logic [11:0] RC_MIN = 12'h002;
  localparam logic [11:0] RC_ZERO = 12'h000;
  localparam logic [1:0] LEN_1 = 2'h0;
  localparam logic [1:0] LEN_2 = 2'h1;
  localparam logic [1:0] LEN_3 = 2'h3;
  localparam logic [1:0] LEN_4P = 2'h2;
  localparam logic [31:0] STK_STEP = 32'h0000_0004;
  localparam logic [31:0] PTR_STEP = 32'h0000_0002;
  localparam int unsigned VEC_SHIFT = 2;

  typedef enum logic [2:0] {
    CS_STATUS = 3'h0, CS_GBASE = 3'h1, CS_VBASE = 3'h2,
    CS_LSTART = 3'h3, CS_LEND = 3'h4, CS_MOD = 3'h5
  } dcrf_ctl_sel_t;

  typedef enum logic [1:0] {AM_NONE = 2'h0, AM_INC = 2'h1, AM_DEC = 2'h2, AM_IDX = 2'h3} dcrf_amode_t;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01, ST_PSH_SR = 6'h02, ST_PSH_PC = 6'h04,
    ST_POP_PC = 6'h08, ST_POP_SR = 6'h10, ST_POP_END = 6'h20
  } dcrf_state_t;

  typedef struct packed {
    logic en;
    logic [3:0] idx;
    logic [31:0] data;
  } dcrf_gwr_t;

  typedef struct packed {
    logic en;
    dcrf_ctl_sel_t sel;
    logic [31:0] data;
  } dcrf_cwr_t;

  typedef struct packed {
    logic en;
    logic [1:0] sel;
    dcrf_amode_t mode;
  } dcrf_areq_t;
endpackage
